// ===== verilog/tcs_engine.sv
/*
 * Task context-switch engine: holds the 28 architectural registers and
 * swaps them with task structures in system memory on interrupt, fault
 * or task-load instruction.
 * Assumes a simple single-word memory port with request/grant handshake
 * on the same clock, and that the core holds off while busy_out is high.
 */
`include "tcs_consts.svh"

module tcs_engine
    import tcs_pkg::*;
#(
    parameter int XLEN = 32
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   rst_b_in,
    input  wire logic                   event_req_in,
    input  wire logic                   task_load_instruction_in,
    input  wire logic                   wr_en_in,
    input  wire logic [4:0]             wr_idx_in,
    input  wire logic [XLEN-1:0]        wr_data_in,
    input  wire logic [4:0]             rd_idx_in,
    output logic      [XLEN-1:0]        rd_data_out,
    output logic                        busy_out,
    output logic                        done_out,
    output logic                        mem_req_out,
    output logic                        mem_we_out,
    output logic      [XLEN-1:0]        mem_addr_out,
    output logic      [XLEN-1:0]        mem_wdata_out,
    input  wire logic                   mem_gnt_in,
    input  wire logic [XLEN-1:0]        mem_rdata_in,
    output logic      [XLEN-1:0]        base_task_pointer_out,
    output logic      [XLEN-1:0]        current_task_pointer_out,
    output logic      [XLEN-1:0]        instruction_pointer_out,
    output logic                        csw_enable_out
);

    localparam int NREG  = `TCS_NUM_REGS;
    localparam int WBYTE = XLEN / 8;

    // only the two address variants exist; refused while elaborating
    if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
        $error("tcs_engine: XLEN must be 32 or 64");
    end

    localparam int AREA = (XLEN == 32) ? `TCS_REG_AREA_32 : `TCS_REG_AREA_64;
    // identifier sits right after the register area
    localparam logic [XLEN-1:0] ID_OFFSET = XLEN'(AREA);

    // identifier left untouched
    // the last saved word must end exactly where the identifier begins,
    // otherwise a save would clobber the task's identifier field
    if (NREG * WBYTE != int'(ID_OFFSET)) begin : g_bad_area
        $error("tcs_engine: register area does not match the word count");
    end

    logic [XLEN-1:0] regs_ff     [NREG];
    logic [XLEN-1:0] nxt_regs    [NREG];
    tcs_state_e      state_ff;
    tcs_state_e      nxt_state;
    tcs_cause_e      cause_ff;
    tcs_cause_e      nxt_cause;
    logic [4:0]      idx_ff;
    logic [4:0]      nxt_idx;
    logic [XLEN-1:0] save_base;
    logic [XLEN-1:0] load_base;
    logic            csw_en;

    // both task pointers live in the register file
    assign base_task_pointer_out    = regs_ff[`TCS_IDX_BASE_TASK];
    assign current_task_pointer_out = regs_ff[`TCS_IDX_CUR_TASK];
    assign instruction_pointer_out  = regs_ff[`TCS_IDX_IP];
    assign csw_en                   = regs_ff[`TCS_IDX_STATUS][`TCS_CSW_EN_BIT];
    assign csw_enable_out           = csw_en;
    assign busy_out                 = (state_ff != TCS_IDLE);
    assign done_out                 = (state_ff == TCS_DONE);

    // event saves to current, loads base; task-load the reverse
    always_comb begin
        if (cause_ff == TCS_CAUSE_LOAD) begin
            save_base = regs_ff[`TCS_IDX_BASE_TASK];
            load_base = regs_ff[`TCS_IDX_CUR_TASK];
        end else begin
            save_base = regs_ff[`TCS_IDX_CUR_TASK];
            load_base = regs_ff[`TCS_IDX_BASE_TASK];
        end
    end

    // word index i at offset i * word size, fixed order
    // combinational, so the first word is offered the cycle after the trigger
    always_comb begin
        mem_req_out   = 1'b0;
        mem_we_out    = 1'b0;
        mem_addr_out  = '0;
        mem_wdata_out = regs_ff[idx_ff];
        if (state_ff == TCS_SAVE) begin
            mem_req_out  = 1'b1;
            mem_we_out   = 1'b1;
            mem_addr_out = save_base + XLEN'(idx_ff) * XLEN'(WBYTE);
        end else if (state_ff == TCS_LOAD) begin
            mem_req_out  = 1'b1;
            mem_addr_out = load_base + XLEN'(idx_ff) * XLEN'(WBYTE);
        end
    end

    // sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cause = cause_ff;
        nxt_idx   = idx_ff;
        case (state_ff)
            TCS_IDLE: begin
                // enable bit gates events only; task-load is never gated
                // task-load always switches, checked first
                if (task_load_instruction_in) begin
                    nxt_state = TCS_SAVE;
                    nxt_cause = TCS_CAUSE_LOAD;
                    nxt_idx   = '0;
                // events ignored while enable bit clear
                end else if (event_req_in && csw_en) begin
                    nxt_state = TCS_SAVE;
                    nxt_cause = TCS_CAUSE_EVENT;
                    nxt_idx   = '0;
                end
            end
            TCS_SAVE: begin
                // whole save completes before loading starts
                if (mem_gnt_in) begin
                    if (idx_ff == 5'(NREG - 1)) begin
                        nxt_state = TCS_LOAD;
                        nxt_idx   = '0;
                    end else begin
                        nxt_idx = idx_ff + 5'd1;
                    end
                end
            end
            TCS_LOAD: begin
                // within a switch, pointer words 4 and 5 only change here, after every save
                if (mem_gnt_in) begin
                    if (idx_ff == 5'(NREG - 1)) begin
                        nxt_state = TCS_DONE;
                    end else begin
                        nxt_idx = idx_ff + 5'd1;
                    end
                end
            end
            TCS_DONE: begin
                // one-cycle done pulse, requests taken again from the edge after next
                nxt_state = TCS_IDLE;
                nxt_cause = TCS_CAUSE_NONE;
            end
            default: begin
                nxt_state = TCS_IDLE;
                nxt_cause = TCS_CAUSE_NONE;
            end
        endcase
    end

    // register file: core writes only while idle, loads land per word
    // a granted load wins; core writes are refused while busy
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        if (state_ff == TCS_LOAD && mem_gnt_in) begin
            nxt_regs[idx_ff] = mem_rdata_in;
        end else if (state_ff == TCS_IDLE && wr_en_in && wr_idx_in < 5'(NREG)) begin
            nxt_regs[wr_idx_in] = wr_data_in;
        end
    end

    // registers only: every decision sits in the comb blocks above
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= TCS_IDLE;
            cause_ff <= TCS_CAUSE_NONE;
            idx_ff   <= '0;
            for (int i = 0; i < NREG; i++) begin
                regs_ff[i] <= '0;
            end
        end else begin
            state_ff <= nxt_state;
            cause_ff <= nxt_cause;
            idx_ff   <= nxt_idx;
            for (int i = 0; i < NREG; i++) begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    // read port, registered; out-of-range index reads zero
    logic [XLEN-1:0] rd_ff;
    logic [XLEN-1:0] nxt_rd;

    always_comb begin
        nxt_rd = (rd_idx_in < 5'(NREG)) ? regs_ff[rd_idx_in] : '0;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_ff <= '0;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    assign rd_data_out = rd_ff;

endmodule

// ===== shared/tcs_consts.svh
/*
 * Constants of the task context-switch engine: register-area layout,
 * structure offsets and status word bit positions.
 * Assumes byte addressing of system memory.
 */
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH

`define TCS_NUM_REGS        28
`define TCS_REG_AREA_32     112
`define TCS_REG_AREA_64     224
`define TCS_ID_BYTES        4
`define TCS_CSW_EN_BIT      2
`define TCS_IDX_IP          0
`define TCS_IDX_STATUS      1
`define TCS_IDX_BASE_TASK   4
`define TCS_IDX_CUR_TASK    5
`define TCS_IDX_PAGE_TABLE  6

`endif

// ===== shared/tcs_pkg.sv
/*
 * Types of the task context-switch engine.
 * Assumes tcs_consts.svh supplies the numeric layout.
 */
package tcs_pkg;

    // one-hot engine states
    typedef enum logic [3:0] {
        TCS_IDLE = 4'b0001,
        TCS_SAVE = 4'b0010,
        TCS_LOAD = 4'b0100,
        TCS_DONE = 4'b1000
    } tcs_state_e;

    // what started the switch
    typedef enum logic [1:0] {
        TCS_CAUSE_NONE  = 2'b00,
        TCS_CAUSE_EVENT = 2'b01,
        TCS_CAUSE_LOAD  = 2'b10
    } tcs_cause_e;

endpackage

// ===== test/tcs_chk.sv
/* checker for the context-switch engine port timing
   bound to every tcs_engine instance, sees its ports only */
module tcs_chk #(
    parameter int XLEN = 32
) (
    input wire logic            sys_clk_in,
    input wire logic            rst_b_in,
    input wire logic            event_req_in,
    input wire logic            task_load_instruction_in,
    input wire logic            busy_out,
    input wire logic            done_out,
    input wire logic            mem_req_out,
    input wire logic            mem_we_out,
    input wire logic [XLEN-1:0] mem_addr_out,
    input wire logic            mem_gnt_in,
    input wire logic [XLEN-1:0] base_task_pointer_out,
    input wire logic [XLEN-1:0] current_task_pointer_out,
    input wire logic            csw_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // start conditions seen from idle
    start_load_a: assert property (task_load_instruction_in && !busy_out |=> busy_out)
        else $error("task load not taken");
    event_take_a: assert property (event_req_in && csw_enable_out && !busy_out |=> busy_out)
        else $error("enabled event not taken");
    event_gate_a: assert property (event_req_in && !csw_enable_out
        && !task_load_instruction_in && !busy_out |=> !busy_out)
        else $error("disabled event switched");
    // first word is a save into the outgoing structure
    save_addr_a: assert property ($rose(busy_out) |-> mem_req_out && mem_we_out
        && mem_addr_out == ($past(task_load_instruction_in) ? base_task_pointer_out
        : current_task_pointer_out)) else $error("wrong first save word");
    // a request holds until granted
    req_hold_a: assert property (mem_req_out && !mem_gnt_in |=> mem_req_out
        && $stable(mem_addr_out) && $stable(mem_we_out)) else $error("request dropped");
    addr_step_a: assert property ((mem_req_out && mem_we_out && mem_gnt_in) ##1 (mem_req_out
        && mem_we_out) |-> mem_addr_out == $past(mem_addr_out) + XLEN / 8) else $error("bad stride");
    // pointers must not move while saving
    ptr_hold_a: assert property (mem_req_out && mem_we_out |-> $stable(base_task_pointer_out)
        && $stable(current_task_pointer_out)) else $error("pointer moved during save");
    done_end_a: assert property (done_out |-> $past(mem_req_out && mem_gnt_in && !mem_we_out)
        ##1 !busy_out) else $error("done misplaced");
endmodule

bind tcs_engine tcs_chk #(.XLEN(XLEN)) chk_u (.sys_clk_in, .rst_b_in, .event_req_in,
    .task_load_instruction_in, .busy_out, .done_out, .mem_req_out, .mem_we_out, .mem_addr_out,
    .mem_gnt_in, .base_task_pointer_out, .current_task_pointer_out, .csw_enable_out);

// ===== test/tcs_mem.sv
/* system memory model holding task structures
   assumes 32-bit words at byte addresses below 2 KiB */
module tcs_mem (
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        slow_in,
    output logic             gnt_out,
    output logic      [31:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] words [512];
    logic        tick = 1'b0;
    // slow mode grants every other cycle to stretch the walk
    assign gnt_out = req_in && (!slow_in || tick);
    // structures prepared by the bench
    // data only valid with a read grant, else a pattern that keeps moving
    assign rdata_out = (gnt_out && !we_in) ? words[addr_in[10:2]] : {16{tick, ~tick}};
    // writes land on the grant edge
    always @(posedge clk_in) begin
        tick <= ~tick;
        if (gnt_out && we_in) words[addr_in[10:2]] <= wdata_in;
    end
endmodule

// ===== test/tb_top.sv
/* bench for the context-switch engine: switch rows, then a mid-switch reset case
   assumes tcs_mem stands on the memory port */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_b = 0, ev = 0, tl = 0, we = 0, slow = 0, busy, done, req, mwe, gnt;
    logic [4:0]  wi = '0, ri = '0;
    logic        cen;
    logic [31:0] wd = '0, rd, addr, wdat, rdat, bp, ip, cp;
    logic [31:0] er [28], src [28];
    // row bits: task load, event, enable, slow memory, switch expected
    logic [4:0]  rows [5] = '{5'h0d, 5'h17, 5'h08, 5'h11, 5'h1d};
    int          fails = 0, checks = 0, n, s;
    always #5 clk = ~clk;
    tcs_engine #(.XLEN(32)) dut_u (.sys_clk_in(clk), .rst_b_in(rst_b), .event_req_in(ev),
        .task_load_instruction_in(tl), .wr_en_in(we), .wr_idx_in(wi), .wr_data_in(wd),
        .rd_idx_in(ri), .rd_data_out(rd), .busy_out(busy), .done_out(done), .mem_req_out(req),
        .mem_we_out(mwe), .mem_addr_out(addr), .mem_wdata_out(wdat), .mem_gnt_in(gnt),
        .mem_rdata_in(rdat), .base_task_pointer_out(bp), .current_task_pointer_out(cp),
        .instruction_pointer_out(ip), .csw_enable_out(cen));
    tcs_mem mem_u (.clk_in(clk), .req_in(req), .we_in(mwe), .addr_in(addr), .wdata_in(wdat),
        .slow_in(slow), .gnt_out(gnt), .rdata_out(rdat));
    // pointers and enable kept equal in every structure
    // paging never enabled, so the page-table pointer word stays free
    function automatic logic [31:0] fv(logic [31:0] b, int i);
        return i == 1 ? 32'h4 : i == 4 ? 32'h200 : i == 5 ? 32'h400 : b + 32'(i);
    endfunction
    task automatic chk(logic [31:0] g, logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(int i, logic [31:0] d);
        @(negedge clk) {we, wi, wd} = {1'b1, 5'(i), d};
        @(negedge clk) we = 0;
    endtask
    // read data is registered, so look one cycle on
    task automatic rdc(int i, logic [31:0] e);
        @(negedge clk) ri = 5'(i);
        @(negedge clk) chk(rd, e);
    endtask
    task automatic complete_run;
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard at 5000 cycles, far beyond the roughly 670 cycles needed
    initial begin
        #50000;
        fails++;
        complete_run;
    end
    initial begin
        for (int i = 0; i < 28; i++) begin
            er[i] = fv(32'hc00, i);
            mem_u.words[128 + i] = fv(32'ha00, i);
            mem_u.words[256 + i] = fv(32'hb00, i);
        end
        mem_u.words[156] = 32'h1d;
        mem_u.words[284] = 32'h2d;
        repeat (8) @(negedge clk);
        rst_b = 1;
        for (int i = 0; i < 28; i++) wr(i, er[i]);
        foreach (rows[r]) begin
            er[1] = rows[r][2] ? 32'h4 : 32'h0;
            wr(1, er[1]);
            slow = rows[r][1];
            s = rows[r][4] ? 256 : 128;
            for (int i = 0; i < 28; i++) src[i] = mem_u.words[s + i];
            @(negedge clk) {tl, ev} = rows[r][4:3];
            n = 0;
            if (rows[r][0]) begin
                do begin
                    @(negedge clk) {tl, ev} = 2'b00;
                    n++;
                end while (done !== 1'b1 && n < 300);
                if (!rows[r][1]) chk(n, 57);
                chk(done, 1);
                for (int i = 0; i < 28; i++) chk(mem_u.words[384 - s + i], er[i]);
                chk(mem_u.words[412 - s], s == 256 ? 32'h1d : 32'h2d);
                er = src;
            end else repeat (4) @(negedge clk) {tl, ev} = 2'b00;
            @(negedge clk) chk(busy, 0);
            for (int i = 0; i < 28; i++) rdc(i, er[i]);
            chk(bp, 32'h200);
            chk(cp, 32'h400);
            chk(cen, er[1][2]);
            chk(ip, er[0]);
        end
        rdc(28, 0);
        // reset in mid-switch drops everything back to idle
        @(negedge clk) tl = 1;
        repeat (10) @(negedge clk) tl = 0;
        rst_b = 0;
        @(negedge clk) chk({busy, req}, 0);
        rst_b = 1;
        rdc(0, 0);
        chk(ip, 0);
        complete_run;
    end
endmodule
